// *** design/sram_erase_pkg.sv ***
/*
 * constants, register map and state codes of the protected ram erase control.
 * assumes a 40 mhz ref_clk and a 32-bit avalon-mm register bus.
 */
package sram_erase_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and register map
  localparam int          BUS_AW        = 5;          // byte address width
  localparam int          BUS_DW        = 32;         // data width
  localparam logic [4:0]  OFS_CTRL      = 5'h00;      // routine start (security access)
  localparam logic [4:0]  OFS_STATUS    = 5'h04;      // busy and event levels
  localparam logic [4:0]  OFS_FLAG      = 5'h08;      // irq_flag_reg
  localparam logic [4:0]  OFS_ENSET     = 5'h0c;      // irq_enable_set_reg
  localparam logic [4:0]  OFS_ENCLR     = 5'h10;      // irq_enable_clear_reg
  localparam logic [4:0]  OFS_KEY       = 5'h14;      // scramble key
  localparam logic [4:0]  OFS_PGATE     = 5'h18;      // dynamic_power_gating_enable
  localparam logic [1:0]  RESP_OK       = 2'h0;       // avalon okay
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;       // avalon slave error
  localparam logic [1:0]  RESP_DECERR   = 2'h3;       // avalon decode error

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          CTRL_START    = 0;          // start remanence routine
  localparam int          ST_REMAN      = 0;          // remanence busy
  localparam int          ST_ERASE      = 1;          // tamper erase busy
  localparam int          ST_TAMPER     = 2;          // synchronised tamper level
  localparam int          IRQ_W         = 2;          // interrupt sources
  localparam int          IRQ_DONE      = 0;          // remanence_done_flag
  localparam int          IRQ_RDERR     = 1;          // read error flag
  localparam logic [31:0] KEY_RESET     = 32'h0000_0000; // key after reset and erase
  localparam logic [0:0]  PGATE_RESET   = 1'h0;       // power gating off

  ////////////////////////////////////////////////////////////////////////////
  // protected ram walk
  localparam int          RAM_AW        = 8;          // ram word address width
  localparam logic [7:0]  RAM_LAST      = 8'hff;      // last word walked
  localparam logic [7:0]  RAM_FIRST     = 8'h00;      // first word walked
  localparam logic [31:0] ERASE_WORD    = 32'h0000_0000; // tamper erase pattern
  localparam logic [31:0] REMAN_WORD    = 32'haaaa_5555; // remanence overwrite pattern

  ////////////////////////////////////////////////////////////////////////////
  // routine state machine, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_RUNREM = 3'b010,
    ST_RUNERA = 3'b100
  } routine_e;

endpackage

// *** design/evt_sync3.sv ***
/*
 * three flip-flop synchroniser for one event level with rise pulse.
 * assumes the input comes from another clock domain or a pin.
 */
`timescale 1ns/1ps
module evt_sync3 (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // asynchronous level in
  input  wire logic async_in,
  // synchronised outputs
  output logic      level_o,
  output logic      rise_o
);

  logic meta_r;                            // first stage, read by stage two only
  logic s2_r;                              // second stage
  logic s3_r;                              // third stage
  logic stable_r;                          // accepted level
  logic stable_nxt;                        // next accepted level

  ////////////////////////////////////////////////////////////////////////////
  // accept a change once stages two and three agree
  always_comb begin
    stable_nxt = (s2_r == s3_r) ? s3_r : stable_r;
  end

  // register all stages
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r   <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      stable_r <= 1'b0;
    end else begin
      meta_r   <= async_in;
      s2_r     <= meta_r;
      s3_r     <= s2_r;
      stable_r <= stable_nxt;
    end
  end

  assign level_o = stable_r;
  assign rise_o  = stable_nxt & ~stable_r;  // one cycle on accepted rise

endmodule

// *** design/irq_cell.sv ***
/*
 * one interrupt source: sticky flag, enable bit and request.
 * assumes set and write strobes are one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
module irq_cell (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // hardware event and software strobes
  input  wire logic set_i,
  input  wire logic flag_clr_i,
  input  wire logic en_set_i,
  input  wire logic en_clr_i,
  // state out
  output logic      flag_o,
  output logic      en_o,
  output logic      req_o
);

  logic flag_r;                            // sticky flag
  logic flag_nxt;
  logic en_r;                              // interrupt enable
  logic en_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next values: set wins over a clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (set_i) begin
      flag_nxt = 1'b1;
    end else if (flag_clr_i) begin
      flag_nxt = 1'b0;
    end
    en_nxt = en_r;
    if (en_set_i) begin
      en_nxt = 1'b1;
    end else if (en_clr_i) begin
      en_nxt = 1'b0;
    end
  end

  // register flag and enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
      en_r   <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      en_r   <= en_nxt;
    end
  end

  assign flag_o = flag_r;
  assign en_o   = en_r;
  assign req_o  = flag_r & en_r;

endmodule

// *** design/secure_ram_erase_control.sv ***
/*
 * protected ram erase control: tamper full erase, remanence routine,
 * key register, two interrupt sources and a clock request for sleep.
 * assumes an avalon-mm master on ref_clk, tamper events from another
 * domain and a ram that accepts one word write per cycle.
 */
`timescale 1ns/1ps
module secure_ram_erase_control
  import sram_erase_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // avalon-mm slave
  input  wire logic [BUS_AW-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [BUS_DW-1:0]   avs_writedata,
  output logic      [BUS_DW-1:0]   avs_readdata,
  output logic      [1:0]          avs_response,
  output logic                     avs_waitrequest,
  // event system
  input  wire logic                tamper_evt,
  // protected ram
  input  wire logic                ram_rd_err,
  output logic                     ram_we,
  output logic      [RAM_AW-1:0]   ram_addr,
  output logic      [BUS_DW-1:0]   ram_wdata,
  output logic      [BUS_DW-1:0]   scramble_key,
  // power
  input  wire logic                sys_sleep,
  output logic                     clk_req,
  output logic                     dynamic_power_gating_enable,
  // interrupt
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                tamper_lvl;          // synchronised tamper level
  logic                tamper_rise;         // one-cycle tamper start
  routine_e            state_r;             // routine state
  routine_e            state_nxt;
  logic [RAM_AW-1:0]   addr_r;              // walk address
  logic [RAM_AW-1:0]   addr_nxt;
  logic [BUS_DW-1:0]   key_r;               // scramble key
  logic [BUS_DW-1:0]   key_nxt;
  logic                pgate_r;             // power gating enable
  logic                pgate_nxt;
  logic                ack_r;               // bus answer phase
  logic                ack_nxt;
  logic [BUS_DW-1:0]   rdata_r;             // read data
  logic [BUS_DW-1:0]   rdata_nxt;
  logic [1:0]          resp_r;              // response code
  logic [1:0]          resp_nxt;
  logic                wr_go;               // write takes effect now
  logic                sec_hit;             // access to security register
  logic                sec_block;           // security access refused
  logic                start_req;           // software start of remanence
  logic                reman_done;          // remanence finished this cycle
  logic [IRQ_W-1:0]    flag_w;              // flags
  logic [IRQ_W-1:0]    en_w;                // enables
  logic [IRQ_W-1:0]    req_w;               // per-source requests
  logic [IRQ_W-1:0]    set_w;               // hardware set pulses

  ////////////////////////////////////////////////////////////////////////////
  // tamper event crossing into the bus clock
  evt_sync3 u_tamper_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (tamper_evt),
    .level_o  (tamper_lvl),
    .rise_o   (tamper_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode helpers
  assign wr_go     = avs_write & ack_r;     // write lands when waitrequest is low
  assign sec_hit   = (avs_address == OFS_CTRL);
  assign sec_block = sec_hit & (state_r == ST_RUNERA);
  assign start_req = wr_go & sec_hit & ~sec_block & avs_writedata[CTRL_START];

  ////////////////////////////////////////////////////////////////////////////
  // routine next state: tamper wins over anything running
  always_comb begin
    state_nxt  = state_r;
    addr_nxt   = addr_r;
    reman_done = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (tamper_rise) begin
          state_nxt = ST_RUNERA;
          addr_nxt  = RAM_FIRST;
        end else if (start_req) begin
          state_nxt = ST_RUNREM;
          addr_nxt  = RAM_FIRST;
        end
      end
      ST_RUNREM: begin
        if (tamper_rise) begin
          state_nxt = ST_RUNERA;
          addr_nxt  = RAM_FIRST;
        end else if (addr_r == RAM_LAST) begin
          state_nxt  = ST_IDLE;
          reman_done = 1'b1;
        end else begin
          addr_nxt = addr_r + 1'b1;
        end
      end
      ST_RUNERA: begin
        if (tamper_rise) begin
          addr_nxt = RAM_FIRST;             // fresh tamper restarts the sweep
        end else if (addr_r == RAM_LAST) begin
          state_nxt = ST_IDLE;
        end else begin
          addr_nxt = addr_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        addr_nxt  = RAM_FIRST;
      end
    endcase
  end

  // register routine state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      addr_r  <= RAM_FIRST;
    end else begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
    end
  end

  // ram write port driven by whichever routine runs
  always_comb begin
    ram_we    = (state_r != ST_IDLE);
    ram_addr  = addr_r;
    ram_wdata = (state_r == ST_RUNERA) ? ERASE_WORD : REMAN_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // key and power gating registers
  // key follows the erase for its whole duration: a write that lands
  // mid-erase is lost silently, so software must rewrite it afterwards
  always_comb begin
    key_nxt   = key_r;
    pgate_nxt = pgate_r;
    if (tamper_rise || state_r == ST_RUNERA) begin
      key_nxt = KEY_RESET;
    end else if (wr_go && avs_address == OFS_KEY) begin
      key_nxt = avs_writedata;
    end
    if (wr_go && avs_address == OFS_PGATE) begin
      pgate_nxt = avs_writedata[0];
    end
  end

  // register key and gating bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      key_r   <= KEY_RESET;
      pgate_r <= PGATE_RESET;
    end else begin
      key_r   <= key_nxt;
      pgate_r <= pgate_nxt;
    end
  end

  assign scramble_key                = key_r;
  assign dynamic_power_gating_enable = pgate_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources
  assign set_w[IRQ_DONE]  = reman_done;
  assign set_w[IRQ_RDERR] = ram_rd_err;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      irq_cell u_cell (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .set_i      (set_w[gi]),
        .flag_clr_i (wr_go & (avs_address == OFS_FLAG) & avs_writedata[gi]),
        .en_set_i   (wr_go & (avs_address == OFS_ENSET) & avs_writedata[gi]),
        .en_clr_i   (wr_go & (avs_address == OFS_ENCLR) & avs_writedata[gi]),
        .flag_o     (flag_w[gi]),
        .en_o       (en_w[gi]),
        .req_o      (req_w[gi])
      );
    end
  endgenerate

  assign irq = |req_w;

  ////////////////////////////////////////////////////////////////////////////
  // sleep: logic never gated, clock asked for while work is pending
  assign clk_req = sys_sleep & (tamper_lvl | (state_r != ST_IDLE));

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle, then data and response hold until the next access
  // a refused security access still answers after one wait cycle, so the
  // master never stalls; only the response code tells it apart
  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    resp_nxt  = resp_r;
    if ((avs_read || avs_write) && !ack_r) begin
      rdata_nxt = '0;
      resp_nxt  = RESP_OK;
      case (avs_address)
        OFS_CTRL: begin
          if (sec_block) begin
            resp_nxt = RESP_SLVERR;
          end else begin
            rdata_nxt[CTRL_START] = (state_r == ST_RUNREM);
          end
        end
        OFS_STATUS: begin
          rdata_nxt[ST_REMAN]  = (state_r == ST_RUNREM);
          rdata_nxt[ST_ERASE]  = (state_r == ST_RUNERA);
          rdata_nxt[ST_TAMPER] = tamper_lvl;
        end
        OFS_FLAG:  rdata_nxt[IRQ_W-1:0] = flag_w;
        OFS_ENSET: rdata_nxt[IRQ_W-1:0] = en_w;
        OFS_ENCLR: rdata_nxt[IRQ_W-1:0] = en_w;
        OFS_KEY:   rdata_nxt = '0;          // key is write only, no error
        OFS_PGATE: rdata_nxt[0] = pgate_r;
        default:   resp_nxt = RESP_DECERR;  // unmapped address
      endcase
    end
  end

  // register bus answer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
      resp_r  <= RESP_OK;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
      resp_r  <= resp_nxt;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign avs_response    = resp_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_tamper_first: assert property (@(posedge ref_clk) disable iff (!nrst)
    tamper_rise |=> (state_r == ST_RUNERA) && (addr_r == RAM_FIRST))
    else $error("tamper did not start full erase");

  chk_reman_abort: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_r == ST_RUNREM) && tamper_rise |=> !ram_we || ram_wdata == ERASE_WORD)
    else $error("remanence not stopped by tamper");

  chk_key_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_r == ST_RUNERA) && wr_go && avs_address == OFS_KEY
      |-> avs_response == RESP_OK ##1 key_r == KEY_RESET)
    else $error("key write during erase not dropped quietly");

  chk_sec_error: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_r == ST_RUNERA) && avs_write && !ack_r && sec_hit
      |=> avs_response == RESP_SLVERR && !avs_waitrequest)
    else $error("security access during erase not errored");

  chk_done_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_r == ST_RUNREM) && addr_r == RAM_LAST && !tamper_rise
      |=> flag_w[IRQ_DONE] && state_r == ST_IDLE)
    else $error("remanence end did not set done flag");

  chk_rderr_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    ram_rd_err |=> flag_w[IRQ_RDERR])
    else $error("read error did not set flag");

  chk_irq_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq && !wr_go |=> irq)
    else $error("interrupt dropped without clear or disable");

  chk_irq_raise: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_go && avs_address == OFS_ENSET && avs_writedata[IRQ_RDERR] && flag_w[IRQ_RDERR]
      |=> irq)
    else $error("enabled flag gave no interrupt");

  chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_go && avs_address == OFS_FLAG && avs_writedata[IRQ_RDERR] && !ram_rd_err
      |=> !flag_w[IRQ_RDERR])
    else $error("write one did not clear flag");

  chk_clk_request: assert property (@(posedge ref_clk) disable iff (!nrst)
    sys_sleep && tamper_rise |=> clk_req)
    else $error("no clock request for sleeping event");

endmodule

// *** dv/cpu_bus_model.sv ***
/*
 * cpu side of the avalon-mm register bus: one access task for the bench.
 * assumes readdata and response come from the slave's registers; waitrequest is combinational in the slave.
 */
`timescale 1ns/1ps
module cpu_bus_model
  import sram_erase_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // master request
  output logic      [BUS_AW-1:0] avs_address,
  output logic                   avs_read,
  output logic                   avs_write,
  output logic      [BUS_DW-1:0] avs_writedata,
  // slave answer
  input  wire logic [BUS_DW-1:0] avs_readdata,
  input  wire logic [1:0]        avs_response,
  input  wire logic              avs_waitrequest
);
  ////////////////////////////////////////////////////////////////////////////
  // idle bus from time zero
  initial begin
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one access, held until waitrequest is sampled low; only the bench
  // watchdog ends a wait that never comes
  task automatic access(input logic wr, input logic [BUS_AW-1:0] adr,
                        input logic [BUS_DW-1:0] wd,
                        output logic [BUS_DW-1:0] rdat, output logic [1:0] rsp);
    @(posedge ref_clk);
    avs_address   <= adr;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    rsp  = avs_response;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= ~wd; // released data shows inverse, not stale value
  endtask
endmodule

// *** dv/tb_secure_ram_erase_control.sv ***
/*
 * self-checking bench of the protected ram erase control.
 * assumes cpu_bus_model as bus master; bench drives tamper, ram error, sleep.
 */
`timescale 1ns/1ps
module tb_secure_ram_erase_control
  import sram_erase_pkg::*;
;
  // clock and reset
  logic              ref_clk = 1'b0;
  logic              nrst    = 1'b0;
  // bus wires
  logic [BUS_AW-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [BUS_DW-1:0] avs_writedata;
  logic [BUS_DW-1:0] avs_readdata;
  logic [1:0]        avs_response;
  logic              avs_waitrequest;
  // events, ram, power, irq
  logic              tamper_evt = 1'b0;
  logic              ram_rd_err = 1'b0;
  logic              sys_sleep  = 1'b0;
  logic              ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [BUS_DW-1:0] ram_wdata;
  logic [BUS_DW-1:0] scramble_key;
  logic              clk_req;
  logic              dynamic_power_gating_enable;
  logic              irq;
  // score
  int                fails       = 0;
  int                comparisons = 0;

  always #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // design and cpu model
  secure_ram_erase_control secure_ram_erase_control_i (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .tamper_evt(tamper_evt),
    .ram_rd_err(ram_rd_err), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .scramble_key(scramble_key), .sys_sleep(sys_sleep),
    .clk_req(clk_req), .dynamic_power_gating_enable(dynamic_power_gating_enable),
    .irq(irq));
  cpu_bus_model cpu_bus_model_i (
    .ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write, judge response, let outputs settle
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] x;
    logic [1:0]  r;
    cpu_bus_model_i.access(1'b1, a, d, x, r);
    chk({30'h0, r}, {30'h0, er});
    @(negedge ref_clk);
  endtask

  // read, judge data and response
  task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] x;
    logic [1:0]  r;
    cpu_bus_model_i.access(1'b0, a, '0, x, r);
    chk(x, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // bounded wait for ram write strobe level; a limit that runs out is a mismatch
  int                we_waits;
  task automatic wait_we(input logic lvl);
    for (we_waits = 0; we_waits < 400 && ram_we !== lvl; we_waits++) @(negedge ref_clk);
    chk({31'h0, ram_we}, {31'h0, lvl});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rd(OFS_FLAG, 32'h0, RESP_OK);
    rd(OFS_ENSET, 32'h0, RESP_OK);
    rd(OFS_PGATE, 32'h0, RESP_OK);
    rd(5'h1c, 32'h0, RESP_DECERR); // unmapped
    chk({31'h0, irq}, 32'h0);
    wr(OFS_KEY, 32'h1234_5678, RESP_OK);
    chk(scramble_key, 32'h1234_5678);
    rd(OFS_KEY, 32'h0, RESP_OK); // write only
  endtask

  task automatic t_reman;
    wr(OFS_CTRL, 32'h1, RESP_OK);
    wait_we(1'b1);
    chk(ram_wdata, REMAN_WORD);
    wait_we(1'b0);
    chk(we_waits, {24'h0, RAM_LAST - RAM_FIRST} + 32'h1);
    repeat (2) @(negedge ref_clk);
    rd(OFS_FLAG, 32'h1 << IRQ_DONE, RESP_OK);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_ENSET, 32'h1 << IRQ_DONE, RESP_OK);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_FLAG, 32'h0, RESP_OK);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_ENCLR, 32'h1 << IRQ_DONE, RESP_OK);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_ENSET, 32'h0, RESP_OK);
    wr(OFS_ENSET, 32'h1 << IRQ_DONE, RESP_OK);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_FLAG, 32'h1 << IRQ_DONE, RESP_OK);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_FLAG, 32'h0, RESP_OK);
  endtask

  task automatic t_rderr;
    @(posedge ref_clk);
    ram_rd_err <= 1'b1;
    @(posedge ref_clk);
    ram_rd_err <= 1'b0;
    rd(OFS_FLAG, 32'h1 << IRQ_RDERR, RESP_OK);
    wr(OFS_ENSET, 32'h1 << IRQ_RDERR, RESP_OK);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_FLAG, 32'h1 << IRQ_RDERR, RESP_OK);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_ENCLR, 32'h3, RESP_OK);
  endtask

  task automatic t_tamper;
    wr(OFS_CTRL, 32'h1, RESP_OK);
    wait_we(1'b1);
    repeat (5) @(posedge ref_clk);
    tamper_evt <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(negedge ref_clk);
      if (ram_we === 1'b1 && ram_wdata === ERASE_WORD) break;
    end
    chk({24'h0, ram_addr}, {24'h0, RAM_FIRST});
    chk(ram_wdata, ERASE_WORD);
    rd(OFS_STATUS, (32'h1 << ST_ERASE) | (32'h1 << ST_TAMPER), RESP_OK);
    wr(OFS_KEY, 32'hdead_beef, RESP_OK);
    chk(scramble_key, KEY_RESET);
    wr(OFS_CTRL, 32'h1, RESP_SLVERR);
    @(posedge ref_clk);
    tamper_evt <= 1'b0;
    wait_we(1'b0);
    chk(scramble_key, KEY_RESET);
    rd(OFS_STATUS, 32'h0, RESP_OK);
    rd(OFS_FLAG, 32'h0, RESP_OK);
    wr(OFS_FLAG, 32'h3, RESP_OK);
  endtask

  task automatic t_sleep;
    wr(OFS_PGATE, 32'h1, RESP_OK);
    chk({31'h0, dynamic_power_gating_enable}, 32'h1);
    @(posedge ref_clk);
    sys_sleep <= 1'b1;
    @(negedge ref_clk);
    chk({31'h0, clk_req}, 32'h0);
    @(posedge ref_clk);
    tamper_evt <= 1'b1;
    for (int n = 0; n < 8 && clk_req !== 1'b1; n++) @(negedge ref_clk);
    chk({31'h0, clk_req}, 32'h1);
    wait_we(1'b1);
    chk(ram_wdata, ERASE_WORD);
    @(posedge ref_clk);
    tamper_evt <= 1'b0;
    wait_we(1'b0);
    repeat (5) @(negedge ref_clk);
    chk({31'h0, clk_req}, 32'h0);
    @(posedge ref_clk);
    sys_sleep <= 1'b0;
  endtask

  // reset in mid-run drops a standing request, flags, enables and gating
  task automatic t_midrst;
    wr(OFS_ENSET, 32'h1 << IRQ_RDERR, RESP_OK);
    @(posedge ref_clk);
    ram_rd_err <= 1'b1;
    @(posedge ref_clk);
    ram_rd_err <= 1'b0;
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, dynamic_power_gating_enable}, 32'h0);
    rd(OFS_FLAG, 32'h0, RESP_OK);
    rd(OFS_ENSET, 32'h0, RESP_OK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic test_done;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_reman();
    t_rderr();
    t_tamper();
    t_sleep();
    t_midrst();
    test_done();
  end

  // watchdog, well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule
